//--- shared/dsc_pkg.sv
// constants and carrier types for the double-speed clock select block
package dsc_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] DSC_CTRL_ADDR  = 8'h8F;
   localparam logic [7:0] DSC_CTRL_RESET = 8'h00;
   localparam logic [7:0] DSC_RDATA_IDLE = 8'h00;

   // ==========================================================
   // field positions inside clock_speed_control
   localparam int DSC_BIT_CPU  = 0;
   localparam int DSC_BIT_T0   = 1;
   localparam int DSC_BIT_T1   = 2;
   localparam int DSC_BIT_T2   = 3;
   localparam int DSC_BIT_UART = 4;
   localparam int DSC_BIT_PCA  = 5;
   localparam int DSC_BIT_WD   = 6;
   localparam int DSC_BIT_CAN  = 7;

   // ==========================================================
   // peripheral clock channels, index = field position - 1
   localparam int DSC_NUM_PERIPH = 7;
   localparam int DSC_PER_T0     = 0;
   localparam int DSC_PER_T1     = 1;
   localparam int DSC_PER_T2     = 2;
   localparam int DSC_PER_UART   = 3;
   localparam int DSC_PER_PCA    = 4;
   localparam int DSC_PER_WD     = 5;
   localparam int DSC_PER_CAN    = 6;

   // ==========================================================
   // oscillator periods per machine / peripheral cycle
   localparam logic [3:0] DSC_OSC_PER_FAST = 4'h6;
   localparam logic [3:0] DSC_OSC_PER_STD  = 4'hC;
   localparam logic [3:0] DSC_CNT_ZERO     = 4'h0;
   localparam logic [3:0] DSC_CNT_STEP     = 4'h1;

   // uart modes in which its speed bit counts
   localparam logic [1:0] DSC_UART_MODE_SHIFT = 2'h0;
   localparam logic [1:0] DSC_UART_MODE_FIXED = 2'h2;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic can;
      logic wd;
      logic pca;
      logic uart;
      logic t2;
      logic t1;
      logic t0;
      logic cpu;
   } dsc_ctrl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } dsc_bus_req_t;

   // start-up walk: two cycles for the option strap to settle
   typedef enum logic [1:0] {
      DSC_INIT_SYNC0,
      DSC_INIT_SYNC1,
      DSC_INIT_LOAD,
      DSC_INIT_RUN
   } dsc_init_t;

endpackage

//--- rtl/dsc_sync2.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module dsc_sync2 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // first stage is read by the second stage only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule // dsc_sync2

//--- rtl/dsc_clock_select.sv
// double-speed clock select: divider, bypass and per-peripheral rates
//
// Function
// - double speed gives 6-period CPU cycles
// - divide-by-two stage, bypassed in double speed
// - option bit forces double speed after reset
// - reset clears all speed bits to zero
// - master bit moves CPU; peripherals need cleared bit
// - with master set: cleared 6, set 12
// - peripheral bits ignored while master cleared
// - master cleared: everything runs 12 periods
// - master change applied on divided rising edge
// - register bits CAN down to CPU master
// - uart bit only in modes 0 and 2
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module dsc_clock_select
   import dsc_pkg::*;
(
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst_b,
   // register port
   input  wire dsc_bus_req_t              bus_req,
   output logic [7:0]                     rdata,
   // pins and straps
   input  wire logic                      osc_input,
   input  wire logic                      reset_speed_option,
   // uart operating mode
   input  wire logic [1:0]                uart_mode,
   // cpu clock
   output logic                           cpu_clk,
   output logic                           cpu_cycle,
   output logic                           cpu_x2,
   // peripheral clocks
   output logic [DSC_NUM_PERIPH-1:0]      periph_clk,
   output logic [DSC_NUM_PERIPH-1:0]      periph_cycle,
   output logic [DSC_NUM_PERIPH-1:0]      periph_x2
);

   // ==========================================================
   // declarations
   dsc_ctrl_t                  ctrl;
   dsc_init_t                  init_state;
   logic                       osc_s;
   logic                       opt_s;
   logic                       osc_prev;
   logic                       osc_tick;
   logic                       div2;
   logic                       div2_rise;
   logic                       ctrl_hit;
   logic                       uart_ok;
   logic [3:0]                 cpu_cnt;
   logic [3:0]                 cpu_limit;
   logic [DSC_NUM_PERIPH-1:0]  per_bits;
   logic [DSC_NUM_PERIPH-1:0]  next_periph_x2;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   // ==========================================================
   // pin synchronisation
   dsc_sync2 #(
      .WIDTH (2)
   ) u_sync (
      .clk   (sys_clk),
      .rst_b (rst_b),
      .d     ({reset_speed_option, osc_input}),
      .q     ({opt_s, osc_s})
   );

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_prev <= 1'b0;
      end else begin
         osc_prev <= osc_s;
      end
   end

   // one pulse per oscillator period
   assign osc_tick = osc_s & ~osc_prev;

   // ==========================================================
   // divide-by-two stage
   // divider stage
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         div2 <= 1'b0;
      end else if (osc_tick) begin
         div2 <= ~div2;
      end
   end

   assign div2_rise = osc_tick & ~div2;

   sequence s_div2_rise;
      osc_tick && !div2;
   endsequence

   // ==========================================================
   // start-up walk for the option strap
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         init_state <= DSC_INIT_SYNC0;
      end else begin
         unique case (init_state)
            DSC_INIT_SYNC0: init_state <= DSC_INIT_SYNC1;
            DSC_INIT_SYNC1: init_state <= DSC_INIT_LOAD;
            DSC_INIT_LOAD:  init_state <= DSC_INIT_RUN;
            DSC_INIT_RUN:   init_state <= DSC_INIT_RUN;
         endcase
      end
   end

   // ==========================================================
   // clock_speed_control register
   assign ctrl_hit = (bus_req.addr == DSC_CTRL_ADDR);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= dsc_ctrl_t'(DSC_CTRL_RESET);
      end else begin
         if (bus_req.wr && ctrl_hit) begin
            ctrl <= dsc_ctrl_t'(bus_req.wdata);
         end
         if (init_state == DSC_INIT_LOAD && opt_s) begin
            ctrl.cpu <= 1'b1;
         end
      end
   end

   // unmapped reads and idle cycles answer zero
   // read back
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= DSC_RDATA_IDLE;
      end else if (bus_req.rd && ctrl_hit) begin
         rdata <= ctrl;
      end else begin
         rdata <= DSC_RDATA_IDLE;
      end
   end

   // ==========================================================
   // speed selection, applied only on the divided rising edge
   // glitch-free switch point
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_x2 <= 1'b0;
      end else if (div2_rise) begin
         cpu_x2 <= ctrl.cpu;
      end
   end

   assign per_bits = ctrl[DSC_BIT_CAN:DSC_BIT_T0];
   assign uart_ok  = (uart_mode == DSC_UART_MODE_SHIFT) ||
                     (uart_mode == DSC_UART_MODE_FIXED);

   always_comb begin
      next_periph_x2 = ctrl.cpu ? ~per_bits : '0;
      if (!uart_ok) begin
         next_periph_x2[DSC_PER_UART] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         periph_x2 <= '0;
      end else if (div2_rise) begin
         periph_x2 <= next_periph_x2;
      end
   end

   // ==========================================================
   // cpu phase generator
   // six or twelve periods
   assign cpu_limit = cpu_x2 ? DSC_OSC_PER_FAST : DSC_OSC_PER_STD;

   // a rate change mid-cycle may leave the count past the new
   // limit, so wrap on greater-or-equal
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_cnt   <= DSC_CNT_ZERO;
         cpu_cycle <= 1'b0;
      end else if (osc_tick) begin
         if (cpu_cnt >= cpu_limit - DSC_CNT_STEP) begin
            cpu_cnt   <= DSC_CNT_ZERO;
            cpu_cycle <= 1'b1;
         end else begin
            cpu_cnt   <= cpu_cnt + DSC_CNT_STEP;
            cpu_cycle <= 1'b0;
         end
      end else begin
         cpu_cycle <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_clk <= 1'b0;
      end else begin
         cpu_clk <= cpu_x2 ? osc_s : div2;
      end
   end

   // ==========================================================
   // per-peripheral clocks
   genvar gi;
   generate
      for (gi = 0; gi < DSC_NUM_PERIPH; gi++) begin : g_per
         logic [3:0] cnt;
         logic [3:0] limit;

         assign limit = periph_x2[gi] ? DSC_OSC_PER_FAST
                                      : DSC_OSC_PER_STD;

         always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
               cnt              <= DSC_CNT_ZERO;
               periph_cycle[gi] <= 1'b0;
            end else if (osc_tick) begin
               if (cnt >= limit - DSC_CNT_STEP) begin
                  cnt              <= DSC_CNT_ZERO;
                  periph_cycle[gi] <= 1'b1;
               end else begin
                  cnt              <= cnt + DSC_CNT_STEP;
                  periph_cycle[gi] <= 1'b0;
               end
            end else begin
               periph_cycle[gi] <= 1'b0;
            end
         end

         always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
               periph_clk[gi] <= 1'b0;
            end else begin
               periph_clk[gi] <= periph_x2[gi] ? osc_s : div2;
            end
         end

         a_per_fast_wrap: assert property (
            osc_tick && periph_x2[gi] && cnt == 4'h5
            |=> periph_cycle[gi] && cnt == 4'h0)
            else $error("peripheral fast cycle not six periods");

         // standard count reaches eleven before wrap
         a_per_std_wrap: assert property (
            osc_tick && !periph_x2[gi] && cnt == 4'hA
            |=> !periph_cycle[gi] && cnt == 4'hB)
            else $error("peripheral standard cycle wrapped early");
      end
   endgenerate

   // ==========================================================
   // checks
   sequence s_ctrl_write;
      bus_req.wr && ctrl_hit && init_state == DSC_INIT_RUN;
   endsequence

   sequence s_ctrl_read;
      bus_req.rd && ctrl_hit;
   endsequence

   a_reset_clear: assert property (
      init_state == DSC_INIT_SYNC0 |-> ctrl == DSC_CTRL_RESET
      && !cpu_x2 && periph_x2 == '0)
      else $error("speed bits not clear after reset");

   // strap reaches the master bit, then the cpu rate
   a_strap_load: assert property (
      init_state == DSC_INIT_LOAD && opt_s
      |=> ctrl.cpu ##[0:300] cpu_x2)
      else $error("option strap did not force double speed");

   // write then read returns the same byte
   a_write_read: assert property (
      s_ctrl_write ##1 s_ctrl_read
      |=> rdata == $past(bus_req.wdata, 2))
      else $error("read back differs from last write");

   // master bit sits at position zero
   a_bit_layout: assert property (
      s_ctrl_write |=> ctrl.cpu == $past(bus_req.wdata[DSC_BIT_CPU])
      && ctrl.can == $past(bus_req.wdata[DSC_BIT_CAN]))
      else $error("register field layout wrong");

   // master rate moves only on the divided edge
   a_master_edge: assert property (
      $changed(cpu_x2) |-> $past(osc_tick && !div2))
      else $error("cpu rate changed off the divided edge");

   // after the divided edge the rate follows the bit
   a_master_follow: assert property (
      s_div2_rise |=> cpu_x2 == $past(ctrl.cpu))
      else $error("cpu rate missed the divided edge");

   // six-period machine cycle in double speed
   a_cpu_fast: assert property (
      osc_tick && cpu_x2 && cpu_cnt == 4'h5
      |=> cpu_cycle && cpu_cnt == 4'h0)
      else $error("double-speed machine cycle not six periods");

   // twelve-period machine cycle in standard speed
   a_cpu_std: assert property (
      osc_tick && !cpu_x2 && cpu_cnt == 4'hB
      |=> cpu_cycle && cpu_cnt == 4'h0)
      else $error("standard machine cycle not twelve periods");

   // master clear keeps every peripheral standard
   a_periph_gate: assert property (
      !cpu_x2 && $stable(cpu_x2) |-> periph_x2 == '0)
      else $error("peripheral fast while master clear");

   // peripheral with cleared bit follows master
   a_can_follow: assert property (
      s_div2_rise and (ctrl.cpu && !ctrl.can)
      |=> periph_x2[DSC_PER_CAN])
      else $error("cleared peripheral bit did not follow master");

   // uart stays standard outside modes 0 and 2
   a_uart_mode: assert property (
      s_div2_rise and !uart_ok |=> !periph_x2[DSC_PER_UART])
      else $error("uart fast outside modes 0 and 2");

   // bypass passes the oscillator straight through
   a_div_bypass: assert property (
      cpu_x2 && $stable(cpu_x2) |=> cpu_clk == $past(osc_s))
      else $error("double speed did not bypass divider");

   a_read_idle: assert property (
      !(bus_req.rd && ctrl_hit) |=> rdata == DSC_RDATA_IDLE)
      else $error("read data not idle outside a read");

endmodule // dsc_clock_select

//--- test/dsc_osc_model.sv
// free-running oscillator pin model for the clock select bench
`timescale 1ns/1ps
module dsc_osc_model #(
   parameter int HALF = 5
) (
   // clock
   input  wire logic sys_clk,
   // oscillator pin
   output logic      osc_input
);
   // ==========================================================
   // square wave
   int   cnt = 0;
   logic lvl = 1'b0;

   // half periods of HALF cycles keep highs and lows >= 2 cycles,
   // and the 50% ratio suits the bypassed divider as well
   always @(posedge sys_clk) begin
      if (cnt == HALF - 1) begin
         cnt <= 0;
         lvl <= ~lvl;
      end else begin
         cnt <= cnt + 1;
      end
   end

   assign osc_input = lvl;
endmodule // dsc_osc_model

//--- test/tb.sv
// self-checking bench for the double-speed clock select block
`timescale 1ns/1ps
module tb;
   import dsc_pkg::*;

   // ==========================================================
   // signals
   localparam int OSC_P = 10;
   logic                      sys_clk;
   logic                      rst_b;
   dsc_bus_req_t              bus_req;
   logic [7:0]                rdata;
   logic                      osc_input;
   logic                      reset_speed_option;
   logic [1:0]                uart_mode;
   logic                      cpu_clk;
   logic                      cpu_cycle;
   logic                      cpu_x2;
   logic [DSC_NUM_PERIPH-1:0] periph_clk;
   logic [DSC_NUM_PERIPH-1:0] periph_cycle;
   logic [DSC_NUM_PERIPH-1:0] periph_x2;
   int                        n_fail;
   int                        num_checks;
   int                        n_cyc;

   dsc_clock_select i_dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .bus_req(bus_req),
      .rdata(rdata), .osc_input(osc_input),
      .reset_speed_option(reset_speed_option), .uart_mode(uart_mode),
      .cpu_clk(cpu_clk), .cpu_cycle(cpu_cycle), .cpu_x2(cpu_x2),
      .periph_clk(periph_clk), .periph_cycle(periph_cycle),
      .periph_x2(periph_x2)
   );

   dsc_osc_model #(.HALF(OSC_P / 2)) i_osc (
      .sys_clk(sys_clk), .osc_input(osc_input)
   );

   // ==========================================================
   // helpers
   task automatic print_verdict;
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: %s got %0h want %0h", $time, what, got,
                  exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= dsc_bus_req_t'{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      bus_req <= dsc_bus_req_t'{8'h00, 8'h00, 1'b0, 1'b0};
   endtask

   // data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      bus_req <= dsc_bus_req_t'{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      bus_req <= dsc_bus_req_t'{8'h00, 8'h00, 1'b0, 1'b0};
      #1;
      chk({8'h00, rdata}, {8'h00, exp}, "read data");
   endtask

   // write then read with no idle cycle between the strobes
   task automatic wr_rd_chk(input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= dsc_bus_req_t'{DSC_CTRL_ADDR, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      bus_req <= dsc_bus_req_t'{DSC_CTRL_ADDR, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      bus_req <= dsc_bus_req_t'{8'h00, 8'h00, 1'b0, 1'b0};
      #1;
      chk({8'h00, rdata}, {8'h00, d}, "back-to-back read");
   endtask

   function automatic logic hit(input int idx);
      return (idx == 7) ? cpu_cycle : periph_cycle[idx];
   endfunction

   function automatic logic clk_of(input int idx);
      return (idx == 7) ? cpu_clk : periph_clk[idx];
   endfunction

   // rise-to-rise length of a clock level, in oscillator periods
   task automatic chk_clk(input int idx, input int periods);
      logic [15:0] n;
      logic        was;
      repeat (2) begin
         n = 16'h0000;
         do begin
            was = clk_of(idx);
            @(posedge sys_clk);
            #1;
            n++;
         end while (!(clk_of(idx) === 1'b1 && was === 1'b0) &&
                    n < 16'h0200);
      end
      chk(n, 16'(periods * OSC_P), "clock period");
   endtask

   // first interval after a switch may wrap, so judge the second
   task automatic chk_rate(input int idx, input int periods);
      logic [15:0] n;
      repeat (2) begin
         n = 16'h0000;
         do begin
            @(posedge sys_clk);
            #1;
            n++;
         end while (hit(idx) !== 1'b1 && n < 16'h0200);
      end
      chk(n, 16'(periods * OSC_P), "cycle length");
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      rd_chk(DSC_CTRL_ADDR, 8'h00);
      chk({15'h0000, cpu_x2}, 16'h0000, "cpu rate");
      chk({9'h000, periph_x2}, 16'h0000, "periph rate");
   endtask

   task automatic t_regs;
      wr_rd_chk(8'h3C);
      wr_reg(DSC_CTRL_ADDR, 8'hA5);
      wr_reg(8'h8E, 8'hFF);
      rd_chk(8'h8E, 8'h00);
      rd_chk(DSC_CTRL_ADDR, 8'hA5);
      @(posedge sys_clk);
      #1;
      chk({8'h00, rdata}, 16'h0000, "idle read data");
   endtask

   task automatic t_std;
      wr_reg(DSC_CTRL_ADDR, 8'h00);
      repeat (50) @(posedge sys_clk);
      #1;
      chk({9'h000, periph_x2}, 16'h0000, "periph rate");
      chk_rate(7, 12);
      chk_rate(DSC_PER_T1, 12);
      chk_clk(7, 2);
   endtask

   task automatic t_fast;
      logic prev;
      prev = 1'b0;
      @(posedge sys_clk);
      uart_mode <= DSC_UART_MODE_SHIFT;
      wr_reg(DSC_CTRL_ADDR, 8'h53);
      #1;
      for (int i = 0; i < 50 && cpu_x2 !== 1'b1; i++) begin
         prev = cpu_clk;
         @(posedge sys_clk);
         #1;
      end
      chk({15'h0000, cpu_x2}, 16'h0001, "cpu rate");
      chk({15'h0000, prev}, 16'h0000, "switch moment");
      repeat (30) @(posedge sys_clk);
      #1;
      chk({9'h000, periph_x2}, 16'h0056, "periph rates");
      chk_rate(7, 6);
      chk_rate(DSC_PER_T0, 12);
      chk_rate(DSC_PER_T1, 6);
      chk_clk(7, 1);
      chk_clk(DSC_PER_T0, 2);
      chk_clk(DSC_PER_T1, 1);
   endtask

   task automatic t_uart;
      wr_reg(DSC_CTRL_ADDR, 8'h01);
      for (int m = 0; m < 4; m++) begin
         @(posedge sys_clk);
         uart_mode <= 2'(m);
         repeat (50) @(posedge sys_clk);
         #1;
         chk({15'h0000, periph_x2[DSC_PER_UART]},
             {15'h0000, (m == 0 || m == 2)}, "uart rate");
      end
   endtask

   task automatic t_strap;
      @(posedge sys_clk);
      rst_b              <= 1'b0;
      reset_speed_option <= 1'b1;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (50) @(posedge sys_clk);
      rd_chk(DSC_CTRL_ADDR, 8'h01);
      chk({15'h0000, cpu_x2}, 16'h0001, "cpu rate");
      chk_rate(7, 6);
   endtask

   // ==========================================================
   // clock, watchdog and main sequence
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      n_cyc++;
      if (n_cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end

   initial begin
      rst_b              = 1'b0;
      bus_req            = dsc_bus_req_t'{8'h00, 8'h00, 1'b0, 1'b0};
      reset_speed_option = 1'b0;
      uart_mode          = 2'h0;
      n_fail             = 0;
      num_checks         = 0;
      n_cyc              = 0;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_reset();
      t_regs();
      t_std();
      t_fast();
      t_uart();
      t_strap();
      print_verdict();
   end
endmodule // tb
